// ### rtl/sbotp_defines.vh
// Shared constants of the synchronous burst read port.
// Assumes inclusion by bare name from each design file of the block that uses it.
`ifndef SBOTP_DEFINES_VH
`define SBOTP_DEFINES_VH

// ****************************************************************
// Mode register layout, loaded from multiplexed_addr
// ****************************************************************
`define SBOTP_MODE_W 5
`define SBOTP_MODE_LAT_LSB 0
`define SBOTP_MODE_LAT_MSB 2
`define SBOTP_MODE_ORDER_BIT 3
`define SBOTP_MODE_LEN8_BIT 4
`define SBOTP_MODE_DEFAULT 5'h06

// ****************************************************************
// Register port map and field positions
// ****************************************************************
`define SBOTP_ADDR_W 4
`define SBOTP_REG_MODE 4'h0
`define SBOTP_REG_STATUS 4'h4
`define SBOTP_ST_BUSY_BIT 0
`define SBOTP_ST_SUSP_BIT 1
`define SBOTP_ST_PDOWN_BIT 2
`define SBOTP_ST_PROG_BIT 3
`define SBOTP_ST_X32_BIT 4
`define SBOTP_ST_ROW_LSB 16

// ****************************************************************
// Widths and counts
// ****************************************************************
`define SBOTP_ROW_W 13
`define SBOTP_COL_W 9
`define SBOTP_CORE_W 22
`define SBOTP_LAT_W 3
`define SBOTP_LAT_OFFSET 3'h2
`define SBOTP_BEATS4 4'h4
`define SBOTP_BEATS8 4'h8
`define SBOTP_ONE3 3'h1

`endif

// ### rtl/sbotp_sync3.v
// Three-stage synchroniser for a level arriving from outside sys_clk.
// Assumes a static or slowly changing level such as a mode strap.
`timescale 1ns/100ps

// ****************************************************************
// Synchroniser
// ****************************************************************
module sbotp_sync3 (
    input wire sys_clk,
    input wire resetn,
    input wire async_in,
    output reg sync_out
);
    reg stage1;
    reg stage2;
    reg stage3;

    // The output moves only when stages two and three agree, so a
    // metastable first stage can never leak into the result.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                sync_out <= stage3;
            end
        end
    end
endmodule // sbotp_sync3

// ### rtl/sbotp_burst_seq.v
// Column generator for one burst beat, sequential or interleaved.
// Assumes the burst length is 4 or 8 and beat index below it.
`timescale 1ns/100ps
`include "sbotp_defines.vh"

// ****************************************************************
// Burst order
// ****************************************************************
module sbotp_burst_seq (
    input wire [`SBOTP_COL_W-1:0] start_col,
    input wire [2:0] beat,
    input wire len8,
    input wire interleave,
    output reg [`SBOTP_COL_W-1:0] beat_col
);
    reg [2:0] wrap_mask;
    reg [2:0] low_bits;

    // Only the low bits inside the burst window move; the rest of the
    // column stays put so a burst never leaves its aligned block.
    always @* begin
        wrap_mask = len8 ? 3'h7 : 3'h3;
        if (interleave) begin
            low_bits = start_col[2:0] ^ beat;
        end else begin
            low_bits = start_col[2:0] + beat;
        end
        beat_col = {start_col[`SBOTP_COL_W-1:3],
                    (start_col[2:0] & ~wrap_mask) | (low_bits & wrap_mask)};
    end
endmodule // sbotp_burst_seq

// ### rtl/sbotp_read_port.v
// Synchronous burst read port of a one-time-programmable memory.
// Assumes the controller pins are driven from logic on sys_clk, the
// array answers core_addr with core_data within the same cycle, and a
// pad ring resolves read_data from the two output enables.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "sbotp_defines.vh"

// What this block and its controller do
// R1: All inputs captured on rising sys_clk only.
// R2: Commands accepted only with select low.
// R3: Gate low freezes the following clock cycle.
// R4: Controller keeps gate high with commands.
// R5: Gating gives clock suspend or power-down.
// R6: Row half is thirteen address bits.
// R7: Column eight bits x32, nine bits x16.
// R8: Data driven only in read cycles.
// R9: Output mask acts two cycles later.
// R10: Width select at read picks organisation.
// R11: Upper sixteen outputs off in x16.
// R12: Burst read only with programming select low.
// R13: Controller picks latency suited to clock.
// R14: Bursts of 4 or 8, sequential/interleaved.
// R15: No precharge or refresh, single bank.
// R16: Mode register self-loads defaults at reset.
// R17: First command is activate or mode load.
// R18: Don't-care inputs are ignored.
// R19: Strobe combination decodes the command.
module sbotp_read_port (
    input wire sys_clk,
    input wire resetn,
    input wire clock_gate_input,
    input wire device_select_n,
    input wire row_strobe_n,
    input wire column_strobe_n,
    input wire mode_load_strobe_n,
    input wire [`SBOTP_ROW_W-1:0] multiplexed_addr,
    input wire output_mask,
    input wire width_select,
    input wire programming_mode_select,
    output reg [31:0] read_data,
    output reg read_data_oe_lo,
    output reg read_data_oe_hi,
    output reg [`SBOTP_CORE_W-1:0] core_addr,
    input wire [31:0] core_data,
    input wire [`SBOTP_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata
);
    // ************************************************************
    // States
    // ************************************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_BURST = 3'b100;

    // Sequencer state, latched command fields and the beat pipeline.
    reg [2:0] state;
    reg [2:0] next_state;
    reg clk_en;
    reg [`SBOTP_MODE_W-1:0] mode;
    reg [`SBOTP_ROW_W-1:0] row;
    reg [`SBOTP_COL_W-1:0] start_col;
    reg x32;
    reg [`SBOTP_LAT_W-1:0] wait_cnt;
    reg [3:0] beat;
    reg fetch_valid;
    reg fetch_half;
    reg mask_q;
    // Decoded commands and values derived from the mode register.
    wire prog_mode;
    wire [`SBOTP_COL_W-1:0] beat_col;
    wire accept;
    wire cmd_mode;
    wire cmd_row;
    wire cmd_read;
    wire [3:0] burst_len;
    wire issue;
    wire [`SBOTP_COL_W-1:0] col_in;
    wire [`SBOTP_LAT_W-1:0] latency;

    // ************************************************************
    // Submodules
    // ************************************************************
    // The strap comes from a board pin, so it crosses into sys_clk.
    sbotp_sync3 u_prog_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .async_in(programming_mode_select),
        .sync_out(prog_mode)
    );

    sbotp_burst_seq u_seq (
        .start_col(start_col),
        .beat(beat[2:0]),
        .len8(mode[`SBOTP_MODE_LEN8_BIT]),
        .interleave(mode[`SBOTP_MODE_ORDER_BIT]),
        .beat_col(beat_col)
    );

    // ************************************************************
    // Clock gate and command decode
    // ************************************************************
    // The gate sampled at one edge decides whether the next edge
    // advances anything, which freezes exactly the following cycle.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            clk_en <= 1'b1;
        end else begin
            clk_en <= clock_gate_input; // R1 R3
        end
    end

    // A command needs the previous gate high and select low; the
    // controller guarantees the gate during command cycles.
    assign accept = clk_en && !device_select_n && !prog_mode; // R2 R4 R12
    // Only the three strobes are decoded; every other pin level is
    // left unread here.
    assign cmd_mode = accept && !row_strobe_n && !column_strobe_n
                      && !mode_load_strobe_n; // R19 R18
    assign cmd_row = accept && !row_strobe_n && column_strobe_n
                     && mode_load_strobe_n; // R19 R17
    assign cmd_read = accept && row_strobe_n && !column_strobe_n
                      && mode_load_strobe_n; // R19 R15
    // In x32 the ninth column bit is not part of the address.
    assign col_in = width_select ?
                    {1'b0, multiplexed_addr[`SBOTP_COL_W-2:0]} :
                    multiplexed_addr[`SBOTP_COL_W-1:0]; // R7 R10
    assign burst_len = mode[`SBOTP_MODE_LEN8_BIT] ?
                       `SBOTP_BEATS8 : `SBOTP_BEATS4; // R14
    // Latencies below three are not supported; the host picks 4 to 6.
    assign latency = mode[`SBOTP_MODE_LAT_MSB:`SBOTP_MODE_LAT_LSB];
    // One fetch leaves on the last wait cycle and on each later beat;
    // a frozen cycle issues none, which stretches the burst by one.
    assign issue = clk_en && (((state == ST_WAIT)
                   && (wait_cnt <= `SBOTP_ONE3))
                   || ((state == ST_BURST) && (beat < burst_len)));

    // ************************************************************
    // Mode register and address latches
    // ************************************************************
    // Reset stands in for power-on: defaults load with no sequence.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            mode <= `SBOTP_MODE_DEFAULT; // R16
            row <= {`SBOTP_ROW_W{1'b0}};
            start_col <= {`SBOTP_COL_W{1'b0}};
            x32 <= 1'b0;
        end else begin
            // A pin mode load wins over a register write in one cycle.
            if (cmd_mode) begin
                mode <= multiplexed_addr[`SBOTP_MODE_W-1:0];
            end else if (reg_wr && (reg_addr == `SBOTP_REG_MODE)) begin
                mode <= reg_wdata[`SBOTP_MODE_W-1:0];
            end
            if (cmd_row) begin
                row <= multiplexed_addr; // R6
            end
            if (cmd_read) begin
                start_col <= col_in; // R7
                x32 <= width_select; // R10
            end
        end
    end

    // ************************************************************
    // Burst sequencer
    // ************************************************************
    // A new read restarts the burst; programming mode aborts it.
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cmd_read) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cmd_read) begin
                    next_state = ST_WAIT;
                end else if (issue) begin
                    next_state = ST_BURST;
                end
            end
            ST_BURST: begin
                if (cmd_read) begin
                    next_state = ST_WAIT;
                end else if (clk_en && (beat >= burst_len)) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (prog_mode) begin
            next_state = ST_IDLE; // R12
        end
    end

    // Frozen cycles hold every stage, which is the clock suspend.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            state <= ST_IDLE;
            wait_cnt <= {`SBOTP_LAT_W{1'b0}};
            beat <= 4'h0;
            core_addr <= {`SBOTP_CORE_W{1'b0}};
            fetch_valid <= 1'b0;
            fetch_half <= 1'b0;
        end else begin
            state <= next_state;
            if (cmd_read) begin
                // Two cycles of the latency go to array and output.
                wait_cnt <= latency - `SBOTP_LAT_OFFSET;
                beat <= 4'h0;
            end else if (clk_en && (state == ST_WAIT)) begin
                wait_cnt <= wait_cnt - `SBOTP_ONE3;
            end
            if (clk_en) begin // R3 R5
                fetch_valid <= issue && !prog_mode && !cmd_read;
                if (issue && !cmd_read) begin
                    beat <= beat + 4'h1; // R14
                    if (x32) begin
                        core_addr <= {row, beat_col[`SBOTP_COL_W-2:0],
                                      1'b0};
                    end else begin
                        core_addr <= {row, beat_col};
                    end
                    // The odd word of an x16 pair sits in the upper lanes.
                    fetch_half <= !x32 && beat_col[0];
                end
            end
        end
    end

    // ************************************************************
    // Output stage
    // ************************************************************
    // The mask is taken at one edge and gates the enable set at the
    // next, so the data the host samples two edges on are hidden.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            mask_q <= 1'b0;
            read_data <= 32'h0000_0000;
            read_data_oe_lo <= 1'b0;
            read_data_oe_hi <= 1'b0;
        end else if (prog_mode) begin
            read_data_oe_lo <= 1'b0; // R12
            read_data_oe_hi <= 1'b0;
        end else if (clk_en) begin
            mask_q <= output_mask; // R9
            // Data still arriving from the array is loaded into read_data even when
            // masked, so unmasking mid-burst costs no refetch.
            if (fetch_valid) begin
                // In x16 the upper lanes read zero behind their enable.
                if (fetch_half) begin
                    read_data <= {16'h0000, core_data[31:16]};
                end else if (x32) begin
                    read_data <= core_data;
                end else begin
                    read_data <= {16'h0000, core_data[15:0]};
                end
            end
            read_data_oe_lo <= fetch_valid && !mask_q; // R8 R9
            read_data_oe_hi <= fetch_valid && !mask_q && x32; // R11
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    // Reads answer one cycle later; unmapped addresses read zero.
    always @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= 32'h0000_0000;
            case (reg_addr)
                `SBOTP_REG_MODE: begin
                    reg_rdata[`SBOTP_MODE_W-1:0] <= mode;
                end
                // Status bits are snapshots and may change at the next edge.
                `SBOTP_REG_STATUS: begin
                    reg_rdata[`SBOTP_ST_BUSY_BIT] <= (state != ST_IDLE);
                    reg_rdata[`SBOTP_ST_SUSP_BIT] <= !clk_en
                                                   && (state != ST_IDLE);
                    reg_rdata[`SBOTP_ST_PDOWN_BIT] <= !clk_en
                                                    && (state == ST_IDLE);
                    reg_rdata[`SBOTP_ST_PROG_BIT] <= prog_mode;
                    reg_rdata[`SBOTP_ST_X32_BIT] <= x32;
                    reg_rdata[`SBOTP_ST_ROW_LSB+`SBOTP_ROW_W-1:
                              `SBOTP_ST_ROW_LSB] <= row;
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // sbotp_read_port

// ### tb/sbotp_core_model.sv
// Behavioural array that stands behind the read port.
// Assumes core_addr counts 16-bit words and holds for a whole cycle.
`timescale 1ns/100ps

// ****************************************************************
// Array model
// ****************************************************************
module sbotp_core_model (
    input wire [21:0] core_addr,
    output reg [31:0] core_data
);
    // Even word low, odd word high, ready within the cycle so that the
    // port takes the pair at the next edge.
    always @* begin
        core_data[15:0] = {core_addr[15:1], 1'b0} ^ 16'h3c5a;
        core_data[31:16] = {core_addr[15:1], 1'b1} ^ 16'h3c5a;
    end
endmodule // sbotp_core_model

// ### tb/sbotp_read_port_sva.sv
// Port checker of the burst read port.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/100ps
`include "sbotp_defines.vh"

// ****************************************************************
// Checker
// ****************************************************************
module sbotp_read_port_sva (
    input wire sys_clk,
    input wire resetn,
    input wire clock_gate_input,
    input wire device_select_n,
    input wire row_strobe_n,
    input wire column_strobe_n,
    input wire mode_load_strobe_n,
    input wire output_mask,
    input wire programming_mode_select,
    input wire [31:0] read_data,
    input wire read_data_oe_lo,
    input wire read_data_oe_hi,
    input wire [`SBOTP_ADDR_W-1:0] reg_addr,
    input wire reg_rd,
    input wire [31:0] reg_rdata
);
    reg gate_d;
    reg [4:0] rd_age;
    reg [3:0] prog_cnt;

    // Age counts running edges only, so a suspended read is not late.
    always @(posedge sys_clk) begin
        gate_d <= clock_gate_input;
        if (!resetn) begin
            rd_age <= 5'h1f;
            prog_cnt <= 4'h0;
        end else begin
            if (gate_d && !device_select_n && row_strobe_n &&
                !column_strobe_n && mode_load_strobe_n) begin
                rd_age <= 5'h0;
            end else if (gate_d && rd_age != 5'h1f) begin
                rd_age <= rd_age + 5'h1;
            end
            if (!programming_mode_select) begin
                prog_cnt <= 4'h0;
            end else if (prog_cnt != 4'h8) begin
                prog_cnt <= prog_cnt + 4'h1;
            end
        end
    end

    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_upper_pairs: assert property (
        read_data_oe_hi |-> read_data_oe_lo)
        else $error("upper half driven alone");
    a_mask_two: assert property (
        gate_d && clock_gate_input && output_mask |->
        ##2 !read_data_oe_lo && !read_data_oe_hi)
        else $error("mask late");
    a_freeze_hold: assert property (
        !clock_gate_input |->
        ##2 $stable(read_data) && $stable(read_data_oe_lo))
        else $error("outputs moved while frozen");
    a_reset_quiet: assert property (
        $rose(resetn) |-> !read_data_oe_lo && read_data == 32'h0)
        else $error("outputs busy after reset");
    a_prog_blocks: assert property (
        prog_cnt == 4'h8 |-> !read_data_oe_lo && !read_data_oe_hi)
        else $error("driving in programming mode");
    a_read_latency: assert property (
        $rose(read_data_oe_lo) |-> rd_age >= 5'd3 && rd_age <= 5'd13)
        else $error("drive without a read command");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0)
        else $error("register data without read");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr == 4'h8 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule // sbotp_read_port_sva

bind sbotp_read_port sbotp_read_port_sva i_sbotp_read_port_sva (
    .sys_clk(sys_clk), .resetn(resetn),
    .clock_gate_input(clock_gate_input),
    .device_select_n(device_select_n), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n),
    .mode_load_strobe_n(mode_load_strobe_n), .output_mask(output_mask),
    .programming_mode_select(programming_mode_select),
    .read_data(read_data), .read_data_oe_lo(read_data_oe_lo),
    .read_data_oe_hi(read_data_oe_hi), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// ### tb/sbotp_read_port_tb_top.sv
// Self-checking bench of the burst read port.
// Assumes the array model answers core_addr within the same cycle.
`timescale 1ns/100ps
`include "sbotp_defines.vh"

// ****************************************************************
// Bench
// ****************************************************************
module sbotp_read_port_tb_top;
    reg sys_clk, resetn, clock_gate_input, device_select_n;
    reg row_strobe_n, column_strobe_n, mode_load_strobe_n;
    reg output_mask, width_select, programming_mode_select;
    reg reg_wr, reg_rd;
    reg [`SBOTP_ROW_W-1:0] multiplexed_addr, row;
    reg [`SBOTP_ADDR_W-1:0] reg_addr;
    reg [31:0] reg_wdata, got;
    wire [31:0] read_data, reg_rdata, core_data;
    wire read_data_oe_lo, read_data_oe_hi;
    wire [`SBOTP_CORE_W-1:0] core_addr;
    integer err_total, n_tests, k, n;

    sbotp_read_port i_sbotp_read_port (
        .sys_clk(sys_clk), .resetn(resetn),
        .clock_gate_input(clock_gate_input),
        .device_select_n(device_select_n), .row_strobe_n(row_strobe_n),
        .column_strobe_n(column_strobe_n),
        .mode_load_strobe_n(mode_load_strobe_n),
        .multiplexed_addr(multiplexed_addr), .output_mask(output_mask),
        .width_select(width_select),
        .programming_mode_select(programming_mode_select),
        .read_data(read_data), .read_data_oe_lo(read_data_oe_lo),
        .read_data_oe_hi(read_data_oe_hi), .core_addr(core_addr),
        .core_data(core_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );
    sbotp_core_model i_sbotp_core_model (
        .core_addr(core_addr), .core_data(core_data)
    );

    // Expected array word, kept apart from the model on purpose.
    function [15:0] wd(input [21:0] a);
        wd = a[15:0] ^ 16'h3c5a;
    endfunction

    task check(input [31:0] exp, input [31:0] seen, input string what);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch %0s exp %h got %h", what, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One command edge; strobes are {row, column, mode load}.
    task cmd(input cs, input w, input [2:0] s, input [12:0] a);
        @(posedge sys_clk);
        {row_strobe_n, column_strobe_n, mode_load_strobe_n} <= s;
        device_select_n <= cs;
        multiplexed_addr <= a;
        width_select <= w;
        @(posedge sys_clk);
        {row_strobe_n, column_strobe_n, mode_load_strobe_n} <= 3'h7;
        device_select_n <= 1'b1;
    endtask

    task reg_access(input wr, input [3:0] a, input [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        got = reg_rdata;
    endtask

    // Reads one burst and checks every beat, its order and enables.
    task burst(input w, input [8:0] col, input [2:0] lat, input l8,
        input il);
        integer i, len;
        reg [8:0] c;
        reg [21:0] a;
        len = l8 ? 8 : 4;
        cmd(1'b0, w, 3'h5, {4'h0, col});
        for (k = 1; k <= lat + len; k = k + 1) begin
            @(posedge sys_clk);
            #1;
            i = k - lat + 1;
            c = il ? col ^ i : col & ~(len - 1) | (col + i) & (len - 1);
            a = w ? {row, c[7:0], 1'b0} : {row, c};
            got = {30'h0, read_data_oe_hi, read_data_oe_lo};
            if (i >= 0 && i < len) begin
                check(w ? {wd(a | 1), wd(a)} : {16'h0, wd(a)},
                    read_data, "beat");
                check({30'h0, w, 1'b1}, got, "enables");
            end else begin
                check(32'h0, got, "idle enables");
            end
        end
    endtask

    // Mask one beat, then freeze one edge in a length-8 burst.
    task sc_pause;
        reg [31:0] snap;
        reg_access(1'b1, 4'h0, 32'h16);
        reg_access(1'b0, 4'h0, 32'h0);
        check(32'h16, got, "mode");
        cmd(1'b0, 1'b0, 3'h5, 13'h004);
        for (k = 1; k < 15; k = k + 1) begin
            @(posedge sys_clk);
            output_mask <= (k == 5);
            clock_gate_input <= (k != 8);
            #1;
            got = {31'h0, read_data_oe_lo};
            if (k == 6 || k == 8 || k == 13) check(32'h1, got, "oe");
            if (k == 7 || k == 14) check(32'h0, got, "oe off");
            if (k == 9) snap = read_data;
            if (k == 10) check(snap, read_data, "frozen");
            if (k == 11 && read_data === snap) check(~snap, snap, "moved");
        end
        // Gate low while idle reads back as power-down.
        clock_gate_input <= 1'b0;
        reg_access(1'b0, 4'h4, 32'h0);
        clock_gate_input <= 1'b1;
        check(32'h4, {27'h0, got[4:0]}, "power-down");
    endtask

    // A read with select high, then one in programming mode.
    task sc_refuse;
        for (n = 0; n < 2; n = n + 1) begin
            @(posedge sys_clk);
            programming_mode_select <= (n == 1);
            repeat (6) @(posedge sys_clk);
            cmd(n == 0, 1'b0, 3'h5, 13'h0);
            for (k = 0; k < 9; k = k + 1) begin
                @(posedge sys_clk);
                #1;
                check(32'h0, {31'h0, read_data_oe_lo}, "refused");
            end
            if (n == 1) begin
                reg_access(1'b0, 4'h4, 32'h0);
                check(32'h8, {27'h0, got[4:0]}, "prog status");
            end
        end
        @(posedge sys_clk);
        programming_mode_select <= 1'b0;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        #100000;
        err_total = err_total + 1;
        finish_test;
    end

    initial begin
        {resetn, output_mask, width_select, reg_wr, reg_rd} = 5'h0;
        {programming_mode_select, reg_addr, reg_wdata} = 37'h0;
        {clock_gate_input, device_select_n} = 2'h3;
        {row_strobe_n, column_strobe_n, mode_load_strobe_n} = 3'h7;
        multiplexed_addr = 13'h0;
        row = 13'h1a5b;
        err_total = 0;
        n_tests = 0;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reg_access(1'b0, 4'h0, 32'h0);
        check(32'h6, got, "default mode");
        reg_access(1'b0, 4'h8, 32'h0);
        check(32'h0, got, "unmapped");
        cmd(1'b0, 1'b0, 3'h3, row);
        reg_access(1'b0, 4'h4, 32'h0);
        check({19'h0, row}, {19'h0, got[28:16]}, "row");
        burst(1'b0, 9'h1fd, 3'h6, 1'b0, 1'b0);
        // Latencies 5 and 6 only, as the clock is far above 50 MHz.
        for (n = 0; n < 3; n = n + 1) begin
            got = n == 0 ? 32'h0d : n == 1 ? 32'h16 : 32'h1d;
            cmd(1'b0, 1'b0, 3'h0, got[12:0]);
            burst(n == 1, 9'h1fb, got[2:0], got[4], got[3]);
        end
        sc_pause;
        sc_refuse;
        finish_test;
    end
endmodule // sbotp_read_port_tb_top
